// >>> inc/pmic_link_pkg.sv
/*
  package of constants shared by the serial slave port and the host-side master.
  assumes both ends include this package through package::* imports.

*/
package pmic_link_pkg;
    localparam logic [6:0] SLAVE_ADDR     = 7'h61;
    localparam logic       DIR_WRITE      = 1'b0;
    localparam logic       DIR_READ       = 1'b1;
    localparam int         BYTE_BITS      = 8;
    localparam int         REG_COUNT      = 32;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam int         FUSE_LOAD_CYC  = 4;
    localparam int         REF_CLK_MHZ    = 200;
    localparam int         SCL_KHZ        = 400;
    localparam int         SCL_HALF_CYC   = (REF_CLK_MHZ * 1000) / (SCL_KHZ * 2);

    typedef enum logic [1:0] {
        PM_SHUTDOWN = 2'b00,
        PM_FUSE     = 2'b01,
        PM_STANDBY  = 2'b10,
        PM_ACTIVE   = 2'b11
    } power_state_t;
endpackage

// >>> inc/pmic_link_if.sv
/*
  two-wire link between host master and device slave, open-drain resolved here.
  assumes pullups: a line is low when any party enables its driver.
*/
interface pmic_link_if;
    logic scl_oe_host;
    logic sda_oe_host;
    logic sda_oe_dev;
    logic scl;
    logic sda;

    assign scl = ~scl_oe_host;
    assign sda = ~(sda_oe_host | sda_oe_dev);

    modport device (input scl, input sda, output sda_oe_dev);
    modport host   (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface

// >>> core/pmic_serial_slave.sv
/*
  device end: power-state control plus the two-wire register slave.
  assumes scl is the link clock domain; power and register side run on ref_clk.
*/
module pmic_serial_slave
    import pmic_link_pkg::*;
#(
    parameter int REGS = REG_COUNT
) (
    // system
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    // supply and regulator status
    input  wire logic         supply_ok,
    input  wire logic         regulator_on,
    // link
    pmic_link_if.device       link,
    // register side
    output logic [1:0]        power_state,
    output logic              reg_access,
    output logic              wr_pulse,
    output logic [7:0]        wr_index,
    output logic [7:0]        wr_data
);
    // the register index is decoded on five bits, so at most 32 registers
    if (REGS < 1 || REGS > 32) begin
        $error("REGS out of range");
    end

    // ----------------------------------------------------------------------
    // power states, ref_clk domain
    // ----------------------------------------------------------------------
    logic [2:0]   sup_sync;
    logic         sup_stable;
    power_state_t state;
    logic [3:0]   fuse_cnt;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sup_sync <= 3'h0;
        end else begin
            sup_sync <= {sup_sync[1:0], supply_ok};
        end
    end

    // lockout falls and rises only once two stages agree
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sup_stable <= 1'b0;
        end else if (!sup_sync[1] && !sup_sync[2]) begin
            sup_stable <= 1'b0;
        end else if (sup_sync[1] && sup_sync[2]) begin
            sup_stable <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n || !sup_stable) begin
            state    <= PM_SHUTDOWN;
            fuse_cnt <= 4'h0;
        end else begin
            case (state)
                PM_SHUTDOWN: begin
                    state    <= PM_FUSE;
                    fuse_cnt <= 4'h0;
                end
                PM_FUSE: begin
                    fuse_cnt <= fuse_cnt + 4'h1;
                    if (fuse_cnt == 4'(FUSE_LOAD_CYC - 1)) state <= PM_STANDBY;
                end
                PM_STANDBY: if (regulator_on) state <= PM_ACTIVE;
                PM_ACTIVE:  if (!regulator_on) state <= PM_STANDBY;
                default:    state <= PM_SHUTDOWN;
            endcase
        end
    end

    // register file; fuse load copies the default image
    logic [7:0] regs [REGS];

    always_ff @(posedge ref_clk) begin
        power_state <= state;
        reg_access  <= (state == PM_STANDBY) || (state == PM_ACTIVE);
    end

    // ----------------------------------------------------------------------
    // link side, scl domain
    // ----------------------------------------------------------------------
    logic [2:0] acc_sync;
    logic       link_en;
    // access level crosses into scl domain; slow enough for two stages
    always_ff @(posedge link.scl) begin
        acc_sync <= {acc_sync[1:0], reg_access};
    end
    assign link_en = acc_sync[1] & acc_sync[2];

    // start and stop seen on sda edges while scl high
    logic start_tog, stop_tog;
    logic start_seen;
    // scl stands still during reset, so the link side clears asynchronously, except the acc_sync chain, which has no reset
    always_ff @(negedge link.sda or negedge reset_n) begin
        if (!reset_n) begin
            start_tog <= 1'b0;
        end else if (link.scl) begin
            start_tog <= ~start_tog;
        end
    end
    always_ff @(posedge link.sda or negedge reset_n) begin
        if (!reset_n) begin
            stop_tog <= 1'b0;
        end else if (link.scl) begin
            stop_tog <= ~stop_tog;
        end
    end

    logic       start_ack, stop_ack;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] phase;     // 0 addr, 1 index, 2 data, 3 read
    logic       active, rd_mode, drop, rd_sent;
    logic [7:0] index;
    logic [7:0] tx;
    logic       wr_tog;
    logic [7:0] wr_idx_l, wr_dat_l;

    assign start_seen = start_tog ^ start_ack;

    // sample on rising scl; no oversampling, so any bus rate is served
    always_ff @(posedge link.scl or negedge reset_n) begin
        if (!reset_n) begin
            stop_ack  <= 1'b0;
            start_ack <= 1'b0;
            active    <= 1'b0;
            bitcnt    <= 4'h0;
            shreg     <= 8'h00;
            phase     <= 2'd0;
            rd_mode   <= 1'b0;
            rd_sent   <= 1'b0;
            drop      <= 1'b0;
            index     <= 8'h00;
            tx        <= 8'h00;
            wr_tog    <= 1'b0;
            wr_idx_l  <= 8'h00;
            wr_dat_l  <= 8'h00;
        end else begin
            stop_ack <= stop_tog;
            if (start_seen) begin
                start_ack <= start_tog;
                active    <= 1'b1;
                bitcnt    <= 4'h1;
                phase     <= 2'd0;
                rd_mode   <= 1'b0;
                rd_sent   <= 1'b0;
                drop      <= 1'b0;
                shreg     <= {7'h0, link.sda};
            end else if (stop_tog != stop_ack) begin
                active <= 1'b0;
            end else if (active) begin
                if (bitcnt == 4'(BYTE_BITS)) begin
                    bitcnt <= 4'h0;
                    if (rd_sent && link.sda) active <= 1'b0;
                end else begin
                    bitcnt <= bitcnt + 4'h1;
                    if (bitcnt < 4'(BYTE_BITS)) shreg <= {shreg[6:0], link.sda};
                    if (bitcnt == 4'(BYTE_BITS - 1)) begin
                        case (phase)
                            2'd0: begin
                                if (shreg[6:0] != SLAVE_ADDR || !link_en) drop <= 1'b1;
                                rd_mode <= (link.sda == DIR_READ);
                                phase   <= (link.sda == DIR_READ) ? 2'd3 : 2'd1;
                                tx      <= regs[index[4:0]];
                            end
                            2'd1: begin
                                index <= {shreg[6:0], link.sda};
                                phase <= 2'd2;
                            end
                            2'd2: if (!drop) begin
                                wr_idx_l <= index;
                                wr_dat_l <= {shreg[6:0], link.sda};
                                wr_tog   <= ~wr_tog;
                                index    <= index + 8'h1;
                            end
                            default: rd_sent <= 1'b1;
                        endcase
                    end
                end
            end
        end
    end

    // drive on falling scl so data only moves while clock low
    // once the read byte is out the slave lets go, so the master's nack shows
    logic sda_drive;
    always_ff @(negedge link.scl or negedge reset_n) begin
        if (!reset_n) begin
            sda_drive <= 1'b0;
        end else if (!active || drop || !link_en) begin
            sda_drive <= 1'b0;
        end else if (bitcnt == 4'(BYTE_BITS) && !rd_sent) begin
            sda_drive <= 1'b1;
        end else if (rd_mode && phase == 2'd3 && !rd_sent && bitcnt < 4'(BYTE_BITS)) begin
            sda_drive <= ~tx[3'(7 - bitcnt)];
        end else begin
            sda_drive <= 1'b0;
        end
    end
    assign link.sda_oe_dev = sda_drive;

    // ----------------------------------------------------------------------
    // write events cross back to ref_clk by toggle
    // ----------------------------------------------------------------------
    logic [2:0] wr_sync;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_sync <= 3'h0;
        end else begin
            wr_sync <= {wr_sync[1:0], wr_tog};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_pulse <= 1'b0;
            wr_index <= 8'h00;
            wr_data  <= 8'h00;
        end else begin
            wr_pulse <= (wr_sync[1] ^ wr_sync[2]) && reg_access;
            if (wr_sync[1] ^ wr_sync[2]) begin
                wr_index <= wr_idx_l;
                wr_data  <= wr_dat_l;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (state == PM_FUSE) begin
            for (int i = 0; i < REGS; i++) regs[i] <= REG_RESET;
        end else if ((wr_sync[1] ^ wr_sync[2]) && reg_access && wr_idx_l < 8'(REGS)) begin
            regs[wr_idx_l[4:0]] <= wr_dat_l;
        end
    end
endmodule

// >>> core/pmic_serial_master.sv
/*
  host end: two-wire master issuing single register writes and reads.
  assumes the link clock is made here by dividing ref_clk.
*/
module pmic_serial_master
    import pmic_link_pkg::*;
(
    // system
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    // request
    input  wire logic         req,
    input  wire logic         req_read,
    input  wire logic [7:0]   req_index,
    input  wire logic [7:0]   req_data,
    // answer
    output logic              busy,
    output logic              done,
    output logic              nacked,
    output logic [7:0]        rd_data,
    // link
    pmic_link_if.host         link
);
    typedef enum logic [2:0] {
        M_IDLE  = 3'b000,
        M_START = 3'b001,
        M_BYTE  = 3'b010,
        M_RSTRT = 3'b011,
        M_STOP  = 3'b100
    } mstate_t;

    mstate_t    st;
    logic [15:0] div;
    logic [1:0]  q;
    logic [3:0]  bitn;
    logic [2:0]  byten;
    logic [7:0]  tx, rx;
    logic        rd, scl_lo, sda_lo;
    logic [2:0]  sda_s;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) sda_s <= 3'h0;
        else sda_s <= {sda_s[1:0], link.sda};
    end

    wire tick = (div == 16'(SCL_HALF_CYC / 2 - 1));

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st <= M_IDLE; div <= 16'h0; q <= 2'd0; bitn <= 4'h0; byten <= 3'h0;
            tx <= 8'h00; rx <= 8'h00; rd <= 1'b0; scl_lo <= 1'b0; sda_lo <= 1'b0;
            busy <= 1'b0; done <= 1'b0; nacked <= 1'b0; rd_data <= 8'h00;
        end else begin
            done <= 1'b0;
            div  <= tick ? 16'h0 : div + 16'h1;
            case (st)
                M_IDLE: if (req) begin
                    st <= M_START; busy <= 1'b1; nacked <= 1'b0; rd <= req_read;
                    byten <= 3'h0; q <= 2'd0; div <= 16'h0;
                end
                M_START: if (tick) begin
                    sda_lo <= 1'b1;
                    tx <= {SLAVE_ADDR, (byten == 3'h3) ? DIR_READ : DIR_WRITE};
                    st <= M_BYTE; bitn <= 4'h0; q <= 2'd0;
                end
                M_BYTE: if (tick) begin
                    q <= q + 2'd1;
                    case (q)
                        2'd0: begin
                            scl_lo <= 1'b1;
                            if (bitn < 4'(BYTE_BITS)) sda_lo <= (byten == 3'h4) ? 1'b0 : ~tx[7];
                            else sda_lo <= 1'b0;
                        end
                        2'd1: scl_lo <= 1'b0;
                        2'd2: begin
                            if (bitn < 4'(BYTE_BITS)) rx <= {rx[6:0], sda_s[2]};
                            else if (byten != 3'h4 && sda_s[2]) nacked <= 1'b1;
                        end
                        default: begin
                            scl_lo <= 1'b1;
                            tx <= {tx[6:0], 1'b0};
                            if (bitn == 4'(BYTE_BITS)) begin
                                bitn <= 4'h0; q <= 2'd0;
                                byten <= byten + 3'h1;
                                if (nacked || byten == 3'h4 || (byten == 3'h2 && !rd)) st <= M_STOP;
                                else if (byten == 3'h0) tx <= req_index;
                                else if (byten == 3'h1 && !rd) tx <= req_data;
                                else if (byten == 3'h1) st <= M_RSTRT;
                                else if (byten == 3'h3) rd_data <= rx;
                            end else begin
                                bitn <= bitn + 4'h1;
                            end
                        end
                    endcase
                end
                M_RSTRT: if (tick) begin
                    q <= q + 2'd1;
                    if (q == 2'd0) sda_lo <= 1'b0;
                    if (q == 2'd1) scl_lo <= 1'b0;
                    if (q == 2'd3) begin st <= M_START; byten <= 3'h3; end
                end
                M_STOP: if (tick) begin
                    q <= q + 2'd1;
                    if (q == 2'd0) begin sda_lo <= 1'b1; if (byten == 3'h5) rd_data <= rx; end
                    if (q == 2'd1) scl_lo <= 1'b0;
                    if (q == 2'd3) begin
                        sda_lo <= 1'b0;
                        st <= M_IDLE; busy <= 1'b0; done <= 1'b1;
                    end
                end
                default: st <= M_IDLE;
            endcase
        end
    end
    assign link.scl_oe_host = scl_lo;
    assign link.sda_oe_host = sda_lo;
endmodule

// >>> tb/pmic_link_properties.sv
/*
  checker for the two-wire link: framing, acknowledge and drive rules seen on the wires.
  assumes the interface resolves scl/sda and that all lines are sampled on ref_clk.
*/
module pmic_link_properties
    import pmic_link_pkg::*;
(
    // system
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic supply_ok,
    // link
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_oe_host,
    input wire logic sda_oe_host,
    input wire logic sda_oe_dev
);
    // ----------------------------------------
    // pulse tracking
    // ----------------------------------------
    logic       scl_q;
    logic       sda_q;
    logic       rd_dir;
    logic [5:0] nbit;
    logic [7:0] first;
    logic       start;
    logic       stop;
    logic       rise;
    logic       ack_slot;

    assign start    = scl && scl_q && sda_q && !sda;
    assign stop     = scl && scl_q && !sda_q && sda;
    assign rise     = scl && !scl_q;
    assign ack_slot = (nbit % 6'd9) == 6'd8;

    always_ff @(posedge ref_clk) begin
        scl_q <= reset_n ? scl : 1'b1;
        sda_q <= reset_n ? sda : 1'b1;
    end

    // saturates so a runaway master cannot wrap back into a byte slot
    always_ff @(posedge ref_clk) begin
        if (!reset_n || start) begin
            nbit   <= 6'd0;
            rd_dir <= 1'b0;
        end else if (rise) begin
            nbit <= (nbit == 6'd63) ? nbit : nbit + 6'd1;
            if (nbit < 6'd8)
                first <= {first[6:0], sda};
            if (nbit == 6'd8)
                rd_dir <= first[0];
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_dev_stable_high;   scl && scl_q |-> $stable(sda_oe_dev); endproperty
    property p_host_stable_high;  scl && scl_q && $changed(sda_oe_host) |-> start || stop; endproperty
    property p_start_by_host;     start |-> sda_oe_host && !sda_oe_dev; endproperty
    property p_stop_by_host;      stop |-> !sda_oe_dev; endproperty
    property p_addr_first;        rise && nbit == 6'd8 |-> first[7:1] == SLAVE_ADDR; endproperty
    property p_ack_write;         rise && ack_slot && !rd_dir && supply_ok |-> sda_oe_dev; endproperty
    property p_host_release_ack;  rise && ack_slot && !rd_dir |-> !sda_oe_host; endproperty
    property p_read_nack;         rise && nbit == 6'd17 && rd_dir |-> !sda_oe_host && !sda_oe_dev; endproperty
    property p_dev_quiet_bits;    rise && !ack_slot && !rd_dir |-> !sda_oe_dev; endproperty
    property p_lockout_silent;    (!supply_ok)[*4] |-> !sda_oe_dev; endproperty

    a_dev_stable_high:  assert property (p_dev_stable_high)  else $error("slave moved sda while scl high");
    a_host_stable_high: assert property (p_host_stable_high) else $error("host moved sda while scl high");
    a_start_by_host:    assert property (p_start_by_host)    else $error("start not made by host");
    a_stop_by_host:     assert property (p_stop_by_host)     else $error("stop not made by host");
    a_addr_first:       assert property (p_addr_first)       else $error("first byte is not the address");
    a_ack_write:        assert property (p_ack_write)        else $error("slave missed acknowledge");
    a_host_release_ack: assert property (p_host_release_ack) else $error("host held sda in ack slot");
    a_read_nack:        assert property (p_read_nack)        else $error("read byte was acknowledged");
    a_dev_quiet_bits:   assert property (p_dev_quiet_bits)   else $error("slave drove a host bit");
    a_lockout_silent:   assert property (p_lockout_silent)   else $error("slave drove sda in lockout");

    c_restart: cover property (start && nbit == 6'd19);
    c_read:    cover property (rise && nbit == 6'd17 && rd_dir);
    c_ack_low: cover property (scl_oe_host && sda_oe_dev);
endmodule

// >>> tb/pmic_i2c_slave_mode_ctrl_test.sv
/*
  self-checking bench: host master and device slave joined by the link interface.
  assumes the master makes the link clock; one transaction at a time, next after done.
*/
module pmic_i2c_slave_mode_ctrl_test
    import pmic_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       ref_clk = 1'b0;
    logic       reset_n;
    logic       supply_ok;
    logic       regulator_on;
    logic       req;
    logic       req_read;
    logic [7:0] req_index;
    logic [7:0] req_data;
    logic [1:0] power_state;
    logic       reg_access;
    logic       wr_pulse;
    logic       busy;
    logic       done;
    logic       nacked;
    logic [7:0] wr_index;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] last_idx;
    logic [7:0] last_dat;
    int         n_errors = 0;
    int         samples_checked = 0;
    int         n_wr = 0;

    always #2.5 ref_clk = ~ref_clk;

    pmic_link_if link();

    pmic_serial_slave i_pmic_serial_slave (.ref_clk(ref_clk), .reset_n(reset_n), .supply_ok(supply_ok),
        .regulator_on(regulator_on), .link(link.device), .power_state(power_state), .reg_access(reg_access),
        .wr_pulse(wr_pulse), .wr_index(wr_index), .wr_data(wr_data));
    pmic_serial_master i_pmic_serial_master (.ref_clk(ref_clk), .reset_n(reset_n), .req(req),
        .req_read(req_read), .req_index(req_index), .req_data(req_data), .busy(busy), .done(done),
        .nacked(nacked), .rd_data(rd_data), .link(link.host));
    pmic_link_properties i_pmic_link_properties (.ref_clk(ref_clk), .reset_n(reset_n), .supply_ok(supply_ok),
        .scl(link.scl), .sda(link.sda), .scl_oe_host(link.scl_oe_host), .sda_oe_host(link.sda_oe_host),
        .sda_oe_dev(link.sda_oe_dev));

    always @(posedge ref_clk) begin
        if (wr_pulse === 1'b1) begin
            n_wr <= n_wr + 1;
            last_idx <= wr_index;
            last_dat <= wr_data;
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
            n_errors++;
        end
    endtask

    task automatic hung;
        $display("wrong value at %0t: wait ran out", $time);
        n_errors++;
        tally_and_finish();
    endtask

    task automatic wait_ps(input logic [1:0] s);
        for (int i = 0; i < 200 && power_state !== s; i++) @(posedge ref_clk);
        if (power_state !== s) hung();
    endtask

    // req is held until busy, so the idle-state sampling cannot miss it
    task automatic txn(input logic rd, input logic [7:0] idx, input logic [7:0] dat);
        @(posedge ref_clk);
        req <= 1'b1;
        req_read <= rd;
        req_index <= idx;
        req_data <= dat;
        for (int i = 0; i < 100 && busy !== 1'b1; i++) @(posedge ref_clk);
        if (busy !== 1'b1) hung();
        req <= 1'b0;
        for (int i = 0; i < 40000 && done !== 1'b1; i++) @(posedge ref_clk);
        if (done !== 1'b1) hung();
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic power_up;
        logic seen_fuse;
        seen_fuse = 1'b0;
        check(power_state, PM_SHUTDOWN);
        check(reg_access, 8'h00);
        @(posedge ref_clk) supply_ok <= 1'b1;
        for (int i = 0; i < 200 && power_state !== PM_STANDBY; i++) begin
            @(posedge ref_clk);
            if (power_state === PM_FUSE) seen_fuse = 1'b1;
        end
        check(power_state, PM_STANDBY);
        check(seen_fuse, 8'h01);
        check(reg_access, 8'h01);
        regulator_on <= 1'b1;
        wait_ps(PM_ACTIVE);
        check(reg_access, 8'h01);
        regulator_on <= 1'b0;
        wait_ps(PM_STANDBY);
        check(reg_access, 8'h01);
    endtask

    task automatic write_top;
        int n0;
        n0 = n_wr;
        txn(1'b0, 8'h1F, 8'hA5);
        check(nacked, 8'h00);
        for (int i = 0; i < 200 && n_wr == n0; i++) @(posedge ref_clk);
        check(8'(n_wr - n0), 8'h01);
        check(last_idx, 8'h1F);
        check(last_dat, 8'hA5);
    endtask

    task automatic read_cases;
        int n0;
        n0 = n_wr;
        txn(1'b1, 8'h1F, 8'h00);
        check(nacked, 8'h00);
        check(rd_data, 8'hA5);
        txn(1'b1, 8'h1E, 8'h00);
        check(rd_data, REG_RESET);
        check(8'(n_wr - n0), 8'h00);
    endtask

    task automatic lockout;
        int n0;
        n0 = n_wr;
        @(posedge ref_clk) supply_ok <= 1'b0;
        wait_ps(PM_SHUTDOWN);
        check(reg_access, 8'h00);
        txn(1'b0, 8'h03, 8'h5A);
        check(nacked, 8'h01);
        check(8'(n_wr - n0), 8'h00);
    endtask

    initial begin
        reset_n = 1'b0;
        supply_ok = 1'b0;
        regulator_on = 1'b0;
        req = 1'b0;
        req_read = 1'b0;
        req_index = 8'h00;
        req_data = 8'h00;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        power_up();
        write_top();
        read_cases();
        lockout();
        tally_and_finish();
    end
endmodule
